/* File: hw/smsc_settle_count.sv */
// Down counter that times the clock settle wait after a standby wake.
`timescale 1ns/1ps
module smsc_settle_count
  import smsc_pkg::*;
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Start pulse and wait length in states
  input wire logic i_start,
  input wire logic [SMSC_WAIT_W-1:0] i_load,
  // Status
  output logic o_busy,
  output logic o_done
);

  logic [SMSC_WAIT_W-1:0] cnt_q;
  logic busy_q;

  // The count is loaded with length minus one so terminal count marks the last state.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      cnt_q <= '0;
      busy_q <= 1'b0;
    end else if (i_start) begin
      cnt_q <= i_load - SMSC_WAIT_W'(1); // see R13
      busy_q <= 1'b1;
    end else if (busy_q) begin
      if (cnt_q == '0) begin
        busy_q <= 1'b0;
      end else begin
        cnt_q <= cnt_q - SMSC_WAIT_W'(1);
      end
    end
  end

  assign o_busy = busy_q;
  assign o_done = busy_q && (cnt_q == '0); // see R13

endmodule // smsc_settle_count

/* File: hw/smsc_sync.sv */
// Two flip-flop synchroniser for asynchronous level inputs.
`timescale 1ns/1ps
module smsc_sync #(
  parameter int W = 2
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Asynchronous levels in, synchronised levels out
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  for (genvar g = 0; g < W; g++) begin : g_bit
    logic meta_q;
    logic sync_q;

    // The first stage feeds only the second stage.
    always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
        meta_q <= 1'b0;
        sync_q <= 1'b0;
      end else begin
        meta_q <= i_async[g];
        sync_q <= meta_q;
      end
    end

    assign o_sync[g] = sync_q;
  end

endmodule // smsc_sync

/* File: hw/smsc_top.sv */
// Sleep and software standby sequencing with the module stop control register.
//
// The strobed register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module smsc_top
  import smsc_pkg::*;
#(
  parameter int unsigned P_WAIT_8192 = SMSC_WAIT_8192,
  parameter int unsigned P_WAIT_16384 = SMSC_WAIT_16384,
  parameter int unsigned P_WAIT_32768 = SMSC_WAIT_32768,
  parameter int unsigned P_WAIT_65536 = SMSC_WAIT_65536,
  parameter int unsigned P_WAIT_131072 = SMSC_WAIT_131072
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Register port
  input wire smsc_bus_t i_bus,
  output logic [7:0] o_rd_data,
  // CPU core and pins
  input wire logic i_sleep_exec,
  input wire logic i_ext_irq,
  input wire logic i_hw_standby_n,
  // Power state outputs
  output logic o_cpu_hold,
  output logic o_periph_hold,
  output logic o_osc_stop,
  output logic o_sleep_mode,
  output logic o_sw_standby,
  // Clock output pin gate and per-module halts
  output logic o_clk_out_en,
  output smsc_halt_t o_mod_halt
);

  // ----------------------------------------------------------------
  // Settle wait decode
  // ----------------------------------------------------------------
  function automatic logic [SMSC_WAIT_W-1:0] wait_of(input logic [2:0] code);
    logic [SMSC_WAIT_W-1:0] n;
    n = SMSC_WAIT_W'(P_WAIT_8192);
    unique case (code)
      3'h0: n = SMSC_WAIT_W'(P_WAIT_8192);
      3'h1: n = SMSC_WAIT_W'(P_WAIT_16384);
      3'h2: n = SMSC_WAIT_W'(P_WAIT_32768);
      3'h3: n = SMSC_WAIT_W'(P_WAIT_65536);
      3'h4: n = SMSC_WAIT_W'(P_WAIT_131072);
      3'h5: n = SMSC_WAIT_W'(SMSC_WAIT_1024);
      default: n = SMSC_WAIT_W'(P_WAIT_8192);
    endcase
    return n;
  endfunction

  function automatic logic wait_legal(input logic [2:0] code);
    return code[2:1] != 2'b11;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  logic [1:0] pins_s;
  logic irq_s;
  logic hw_stby_s;

  smsc_sync #(
    .W(2)
  ) u_sync (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_async({i_ext_irq, ~i_hw_standby_n}),
    .o_sync(pins_s)
  );

  assign irq_s = pins_s[1];
  assign hw_stby_s = pins_s[0];

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  logic wr_sys;
  logic wr_ms;
  logic rd_sys;
  logic rd_ms;

  assign wr_sys = i_bus.wr && (i_bus.addr == SMSC_ADDR_SYS_CTRL);
  assign wr_ms = i_bus.wr && (i_bus.addr == SMSC_ADDR_MOD_STOP);
  assign rd_sys = i_bus.rd && (i_bus.addr == SMSC_ADDR_SYS_CTRL);
  assign rd_ms = i_bus.rd && (i_bus.addr == SMSC_ADDR_MOD_STOP);

  // ----------------------------------------------------------------
  // System control: standby select and settle wait select
  // ----------------------------------------------------------------
  logic standby_select_q;
  logic [2:0] settle_wait_select_q;

  // Only reset clears standby select in hardware, so a wake from standby leaves it set.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      standby_select_q <= SMSC_STBY_RST;
    end else if (wr_sys) begin
      standby_select_q <= i_bus.wdata[SMSC_SYS_STBY_BIT]; // see R2
    end
  end

  // An illegal code is refused so the counter always has a defined length.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      settle_wait_select_q <= SMSC_WAIT_RST;
    end else if (wr_sys && wait_legal(i_bus.wdata[SMSC_SYS_WAIT_HI:SMSC_SYS_WAIT_LO])) begin
      settle_wait_select_q <= i_bus.wdata[SMSC_SYS_WAIT_HI:SMSC_SYS_WAIT_LO]; // see R3
    end
  end

  // ----------------------------------------------------------------
  // Module stop control register
  // ----------------------------------------------------------------
  logic [7:0] module_stop_control_q;
  logic [7:0] module_stop_control_d;

  always_comb begin
    module_stop_control_d = module_stop_control_q;
    if (hw_stby_s) begin
      module_stop_control_d = SMSC_MOD_STOP_RST; // see R6
    end else if (wr_ms) begin
      module_stop_control_d = (i_bus.wdata & SMSC_MOD_STOP_WMASK) | SMSC_MOD_STOP_RST; // see R9
    end
  end

  // Software standby entry and exit do not touch this register; hardware standby reloads it.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      module_stop_control_q <= SMSC_MOD_STOP_RST; // see R6
    end else begin
      module_stop_control_q <= module_stop_control_d; // see R7
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_clk_out_en <= 1'b1;
      o_mod_halt <= '0;
    end else begin
      o_clk_out_en <= ~module_stop_control_d[SMSC_MS_CLK_STOP_BIT]; // see R8
      o_mod_halt.timer <= module_stop_control_d[SMSC_MS_TIMER_BIT]; // see R10
      o_mod_halt.serial0 <= module_stop_control_d[SMSC_MS_SER0_BIT]; // see R11
      o_mod_halt.serial1 <= module_stop_control_d[SMSC_MS_SER1_BIT]; // see R11
      o_mod_halt.adc <= module_stop_control_d[SMSC_MS_ADC_BIT]; // see R11
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_rd_data <= 8'h00;
    end else if (rd_sys) begin
      o_rd_data <= {standby_select_q, settle_wait_select_q, 4'h0};
    end else if (rd_ms) begin
      o_rd_data <= module_stop_control_q;
    end else begin
      o_rd_data <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Power state machine
  // ----------------------------------------------------------------
  smsc_state_t state_q;
  smsc_state_t state_d;
  logic settle_start;
  logic settle_done;

  assign settle_start = (state_q == SMSC_STANDBY) && irq_s && !hw_stby_s;

  smsc_settle_count u_settle (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_start(settle_start),
    .i_load(wait_of(settle_wait_select_q)),
    .o_busy(),
    .o_done(settle_done)
  );

  always_comb begin
    state_d = state_q;
    if (hw_stby_s) begin
      state_d = SMSC_RUN;
    end else begin
      unique case (state_q)
        SMSC_RUN: begin
          if (i_sleep_exec) begin
            state_d = standby_select_q ? SMSC_STANDBY : SMSC_SLEEP; // see R1
          end
        end
        SMSC_SLEEP: begin
          if (irq_s) begin
            state_d = SMSC_RUN;
          end
        end
        SMSC_STANDBY: begin
          if (irq_s) begin
            state_d = SMSC_SETTLE; // see R13
          end
        end
        SMSC_SETTLE: begin
          if (settle_done) begin
            state_d = SMSC_RUN; // see R4
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      state_q <= SMSC_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // Hardware standby sets CPU hold, peripheral hold and oscillator stop; the counter wait holds CPU and peripherals alike.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_cpu_hold <= 1'b0;
      o_periph_hold <= 1'b0;
      o_osc_stop <= 1'b0;
      o_sleep_mode <= 1'b0;
      o_sw_standby <= 1'b0;
    end else begin
      o_cpu_hold <= (state_d != SMSC_RUN) || hw_stby_s; // see R4
      o_periph_hold <= (state_d == SMSC_STANDBY) || (state_d == SMSC_SETTLE) || hw_stby_s; // see R4
      o_osc_stop <= (state_d == SMSC_STANDBY) || hw_stby_s;
      o_sleep_mode <= state_d == SMSC_SLEEP;
      o_sw_standby <= state_d == SMSC_STANDBY;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [SMSC_WAIT_W-1:0] settle_len_q;
  logic [SMSC_WAIT_W-1:0] settle_need_q;

  // Counts states spent in the settle wait, for the length check below.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || state_q != SMSC_SETTLE) begin
      settle_len_q <= '0;
    end else begin
      settle_len_q <= settle_len_q + SMSC_WAIT_W'(1);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      settle_need_q <= '0;
    end else if (settle_start) begin
      settle_need_q <= wait_of(settle_wait_select_q);
    end
  end

  chk_sleep_entry: assert property (@(posedge i_clk_sys) disable iff (i_rst) // see R1
    state_q == SMSC_RUN && i_sleep_exec && !hw_stby_s && !standby_select_q
    |=> state_q == SMSC_SLEEP && o_sleep_mode && !o_osc_stop)
    else $error("sleep instruction with select clear did not enter sleep");

  chk_standby_entry: assert property (@(posedge i_clk_sys) disable iff (i_rst) // see R1
    state_q == SMSC_RUN && i_sleep_exec && !hw_stby_s && standby_select_q
    |=> state_q == SMSC_STANDBY && o_sw_standby && o_periph_hold)
    else $error("sleep instruction with select set did not enter standby");

  chk_select_hold: assert property (@(posedge i_clk_sys) disable iff (i_rst) // see R2
    !wr_sys |=> $stable(standby_select_q))
    else $error("standby select changed without a software write");

  chk_wait_code: assert property (@(posedge i_clk_sys) disable iff (i_rst) // see R3
    wr_sys && !wait_legal(i_bus.wdata[SMSC_SYS_WAIT_HI:SMSC_SYS_WAIT_LO])
    |=> $stable(settle_wait_select_q) && wait_legal(settle_wait_select_q))
    else $error("illegal settle wait code was accepted");

  chk_settle_length: assert property (@(posedge i_clk_sys) disable iff (i_rst) // see R4
    state_q == SMSC_SETTLE && settle_done && !hw_stby_s
    |-> settle_len_q == settle_need_q - SMSC_WAIT_W'(1) ##1 state_q == SMSC_RUN)
    else $error("settle wait did not last the selected number of states");

  chk_settle_hold: assert property (@(posedge i_clk_sys) disable iff (i_rst) // see R13
    state_q == SMSC_SETTLE && !settle_done && !hw_stby_s |=> o_cpu_hold && o_periph_hold)
    else $error("CPU released before the settle counter finished");

  chk_ms_reset: assert property (@(posedge i_clk_sys) disable iff (i_rst) // see R6
    hw_stby_s |=> module_stop_control_q == SMSC_MOD_STOP_RST && o_clk_out_en)
    else $error("module stop register not restored in hardware standby");

  chk_ms_keep: assert property (@(posedge i_clk_sys) disable iff (i_rst) // see R7
    state_q != SMSC_RUN && !wr_ms && !hw_stby_s |=> $stable(module_stop_control_q))
    else $error("module stop register changed across software standby");

  chk_clk_gate: assert property (@(posedge i_clk_sys) disable iff (i_rst) // see R8
    wr_ms && !hw_stby_s |=> o_clk_out_en == !$past(i_bus.wdata[SMSC_MS_CLK_STOP_BIT]))
    else $error("clock output gate does not follow its stop bit");

  chk_rsvd_one: assert property (@(posedge i_clk_sys) disable iff (i_rst) // see R9
    rd_ms |=> o_rd_data[SMSC_MS_RSVD_BIT] == 1'b1)
    else $error("reserved module stop bit did not read as one");

  chk_timer_halt: assert property (@(posedge i_clk_sys) disable iff (i_rst) // see R10
    wr_ms && !hw_stby_s |=> o_mod_halt.timer == $past(i_bus.wdata[SMSC_MS_TIMER_BIT]))
    else $error("timer unit halt does not follow its bit");

  chk_halt_map: assert property (@(posedge i_clk_sys) disable iff (i_rst) // see R11
    rd_ms && !hw_stby_s |=> o_rd_data[SMSC_MS_SER0_BIT] == o_mod_halt.serial0
      && o_rd_data[SMSC_MS_SER1_BIT] == o_mod_halt.serial1
      && o_rd_data[SMSC_MS_ADC_BIT] == o_mod_halt.adc)
    else $error("peripheral halt outputs disagree with the register");

endmodule // smsc_top

/* File: include/smsc_pkg.sv */
// Shared constants and types for the standby and module stop controller.
// Function
// R1: Sleep instruction enters sleep mode when standby select is 0, software standby when 1.
// R2: Standby select stays 1 after standby exit; only a software write clears it.
// R3: Settle wait codes 000..101 give 8192,16384,32768,65536,131072,1024 states; 11x illegal.
// R4: After interrupt wake from software standby, CPU and peripherals wait the settle time.
// R5: Software picks a setting giving at least 7 ms with a crystal.
// R6: Module stop register is 8-bit read/write, loads 40h on reset and hardware standby.
// R7: Module stop register keeps its contents across software standby.
// R8: Module stop bit 7 set stops the system clock output; clear lets it run.
// R9: Module stop bit 6 ignores writes and always reads 1.
// R10: Module stop bit 5 set halts the timer unit; clear runs it.
// R11: Timer unit, both serial channels and converter each have their own halt bit.
// R12: Reset is held at least 10 clocks, or 20 on flash parts.
// R13: Settle wait is a system clock counter started at wake; release waits terminal count.
package smsc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] SMSC_ADDR_SYS_CTRL = 8'h00;
  localparam logic [7:0] SMSC_ADDR_MOD_STOP = 8'h01;

  localparam int SMSC_SYS_STBY_BIT = 7;
  localparam int SMSC_SYS_WAIT_HI = 6;
  localparam int SMSC_SYS_WAIT_LO = 4;
  localparam int SMSC_MS_CLK_STOP_BIT = 7;
  localparam int SMSC_MS_RSVD_BIT = 6;
  localparam int SMSC_MS_TIMER_BIT = 5;
  localparam int SMSC_MS_SER1_BIT = 4;
  localparam int SMSC_MS_SER0_BIT = 3;
  localparam int SMSC_MS_ADC_BIT = 0;

  localparam logic SMSC_STBY_RST = 1'b0;
  localparam logic [2:0] SMSC_WAIT_RST = 3'h0;
  localparam logic [7:0] SMSC_MOD_STOP_RST = 8'h40;
  localparam logic [7:0] SMSC_MOD_STOP_WMASK = 8'hB9;

  // ----------------------------------------------------------------
  // Settle wait counts, in system clock states
  // ----------------------------------------------------------------
  localparam int SMSC_WAIT_W = 18;
  localparam int unsigned SMSC_WAIT_8192 = 8192;
  localparam int unsigned SMSC_WAIT_16384 = 16384;
  localparam int unsigned SMSC_WAIT_32768 = 32768;
  localparam int unsigned SMSC_WAIT_65536 = 65536;
  localparam int unsigned SMSC_WAIT_131072 = 131072;
  localparam int unsigned SMSC_WAIT_1024 = 1024;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SMSC_RUN = 2'h0,
    SMSC_STANDBY = 2'h1,
    SMSC_SETTLE = 2'h3,
    SMSC_SLEEP = 2'h2
  } smsc_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } smsc_bus_t;

  typedef struct packed {
    logic timer;
    logic serial0;
    logic serial1;
    logic adc;
  } smsc_halt_t;

endpackage

/* File: test/smsc_top_test.sv */
// Self-checking testbench for the standby and module stop controller.
`timescale 1ns/1ps
module smsc_top_test;
  import smsc_pkg::*;

  // ----------------------------------------------------------------
  // Signals and parameters
  // ----------------------------------------------------------------
  // Short waits keep the run small; the 1024 state wait has no parameter and runs in full.
  localparam int unsigned WAITS [8] = '{16, 20, 24, 28, 32, 1024, 0, 0};
  localparam int CEIL = 30000;
  logic i_clk_sys;
  logic i_rst;
  smsc_bus_t i_bus;
  logic [7:0] o_rd_data;
  logic i_sleep_exec;
  logic i_ext_irq;
  logic i_hw_standby_n;
  logic o_cpu_hold;
  logic o_periph_hold;
  logic o_osc_stop;
  logic o_sleep_mode;
  logic o_sw_standby;
  logic o_clk_out_en;
  smsc_halt_t o_mod_halt;
  int n_fail;
  int comparisons;
  int cycles;
  logic [31:0] seed;
  logic [7:0] ms_q;
  logic [7:0] sc_q;

  smsc_top #(.P_WAIT_8192(16), .P_WAIT_16384(20), .P_WAIT_32768(24), .P_WAIT_65536(28),
    .P_WAIT_131072(32)) dut_u (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_bus(i_bus),
    .o_rd_data(o_rd_data), .i_sleep_exec(i_sleep_exec), .i_ext_irq(i_ext_irq),
    .i_hw_standby_n(i_hw_standby_n), .o_cpu_hold(o_cpu_hold), .o_periph_hold(o_periph_hold),
    .o_osc_stop(o_osc_stop), .o_sleep_mode(o_sleep_mode), .o_sw_standby(o_sw_standby),
    .o_clk_out_en(o_clk_out_en), .o_mod_halt(o_mod_halt));

  initial begin
    i_clk_sys = 1'b0;
    forever #2 i_clk_sys = ~i_clk_sys;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [7:0] ms_exp(input logic [7:0] w);
    return (w & 8'hB9) | 8'h40;
  endfunction

  // An illegal settle code leaves the old code in place but the select bit still takes.
  function automatic logic [7:0] sc_exp(input logic [7:0] prev, input logic [7:0] w);
    logic [2:0] code;
    code = (w[6:5] == 2'h3) ? prev[6:4] : w[6:4];
    return {w[7], code, 4'h0};
  endfunction

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("unexpected %s: expected %0h, seen %0h", name, exp, got);
      n_fail++;
    end
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_clk_sys);
    i_bus.wr <= 1'b0;
  endtask

  task automatic bus_rd(input string name, input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_clk_sys);
    i_bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge i_clk_sys);
    i_bus.rd <= 1'b0;
    #1;
    chk(name, {24'h0, exp}, {24'h0, o_rd_data});
  endtask

  task automatic chk_outs();
    #1;
    chk("clk_out_en", {31'h0, ~ms_q[7]}, {31'h0, o_clk_out_en});
    chk("mod_halt", {28'h0, ms_q[5], ms_q[3], ms_q[4], ms_q[0]}, {28'h0, o_mod_halt});
  endtask

  task automatic pulse_sleep();
    @(posedge i_clk_sys);
    i_sleep_exec <= 1'b1;
    @(posedge i_clk_sys);
    i_sleep_exec <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    #1;
  endtask

  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  always @(posedge i_clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == CEIL) begin
      $display("unexpected timeout: expected end before %0d cycles, seen %0d", CEIL, cycles);
      n_fail++;
      close_out();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int c;
    logic [7:0] w;
    n_fail = 0;
    comparisons = 0;
    cycles = 0;
    seed = 32'hB2B62A30;
    i_rst = 1'b1;
    i_bus = '0;
    i_sleep_exec = 1'b0;
    i_ext_irq = 1'b0;
    i_hw_standby_n = 1'b1;
    repeat (20) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    ms_q = 8'h40;
    sc_q = 8'h00;
    bus_rd("sys_ctrl", 8'h00, 8'h00);
    bus_rd("mod_stop", 8'h01, 8'h40);
    chk_outs();
    $display("test reset values done");

    // Random writes to both registers, corner values to module stop only, and a different unmapped place each pass.
    for (int i = 0; i < 40; i++) begin
      w = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'(rnd());
      bus_wr(8'h01, w);
      ms_q = ms_exp(w);
      bus_rd("mod_stop", 8'h01, ms_q);
      chk_outs();
      w = 8'(rnd());
      bus_wr(8'h00, w);
      sc_q = sc_exp(sc_q, w);
      bus_rd("sys_ctrl", 8'h00, sc_q);
      bus_wr(8'h05 + i[7:0], 8'(rnd()));
      bus_rd("unmapped", 8'h05 + i[7:0], 8'h00);
    end
    $display("test register access done");

    bus_wr(8'h00, 8'h00);
    sc_q = 8'h00;
    pulse_sleep();
    chk("sleep_mode", 1, {31'h0, o_sleep_mode});
    chk("sw_standby", 0, {31'h0, o_sw_standby});
    chk("osc_stop", 0, {31'h0, o_osc_stop});
    chk("cpu_hold", 1, {31'h0, o_cpu_hold});
    i_ext_irq <= 1'b1;
    repeat (5) @(posedge i_clk_sys);
    #1;
    chk("sleep_mode", 0, {31'h0, o_sleep_mode});
    i_ext_irq <= 1'b0;
    repeat (4) @(posedge i_clk_sys);
    $display("test sleep done");

    // The bench clock stands for an external clock source, so every legal settle code may be chosen.
    for (int code = 0; code < 6; code++) begin
      w = 8'(rnd()) & 8'hB9;
      bus_wr(8'h01, w);
      ms_q = ms_exp(w);
      bus_wr(8'h00, {1'b1, code[2:0], 4'h0});
      pulse_sleep();
      chk("sw_standby", 1, {31'h0, o_sw_standby});
      chk("osc_stop", 1, {31'h0, o_osc_stop});
      chk("periph_hold", 1, {31'h0, o_periph_hold});
      i_ext_irq <= 1'b1;
      c = 0;
      while (o_sw_standby !== 1'b0 && c < 10) begin
        @(posedge i_clk_sys);
        #1;
        c++;
      end
      c = 0;
      while (o_cpu_hold !== 1'b0 && c < 1100) begin
        chk("periph_hold", 1, {31'h0, o_periph_hold});
        @(posedge i_clk_sys);
        #1;
        c++;
      end
      chk("settle_len_ok", 1, {31'h0, c == int'(WAITS[code])});
      chk("periph_hold", 0, {31'h0, o_periph_hold});
      i_ext_irq <= 1'b0;
      repeat (4) @(posedge i_clk_sys);
      bus_rd("sys_ctrl", 8'h00, {1'b1, code[2:0], 4'h0});
      bus_rd("mod_stop", 8'h01, ms_q);
      chk_outs();
    end
    bus_wr(8'h00, 8'h00);
    bus_rd("sys_ctrl", 8'h00, 8'h00);
    $display("test software standby done");

    bus_wr(8'h01, 8'hB9);
    i_hw_standby_n <= 1'b0;
    repeat (5) @(posedge i_clk_sys);
    bus_wr(8'h01, 8'hA1);
    bus_rd("mod_stop", 8'h01, 8'h40);
    chk("cpu_hold", 1, {31'h0, o_cpu_hold});
    chk("osc_stop", 1, {31'h0, o_osc_stop});
    i_hw_standby_n <= 1'b1;
    repeat (5) @(posedge i_clk_sys);
    ms_q = 8'h40;
    chk_outs();
    bus_rd("mod_stop", 8'h01, 8'h40);
    $display("test hardware standby done");
    close_out();
  end

endmodule // smsc_top_test
